// file: design/prc_consts.svh
// Constants for the port, reset and clock block
`ifndef PRC_CONSTS_SVH
`define PRC_CONSTS_SVH
// ***************************************
// Clock and timing
// ***************************************
`define PRC_CLK_PERIOD_NS 5
`define PRC_MC_OSC        12
`define PRC_MC_PHASES     6
`define PRC_RST_MC        2
`define PRC_RST_CLKS      (`PRC_MC_OSC * `PRC_RST_MC)
// ***************************************
// Port layout and reset values
// ***************************************
`define PRC_PORT_RST      8'hff
`define PRC_P1_PULLUP     8'hfc
`define PRC_P3_PULLUP     8'hbf
`define PRC_P3_GPIO       8'hbf
`define PRC_P1_CMP_PLUS   0
`define PRC_P1_CMP_MINUS  1
`define PRC_P3_RXD        0
`define PRC_P3_TXD        1
`define PRC_P3_IRQ0       2
`define PRC_P3_IRQ1       3
`define PRC_P3_CNT0       4
`define PRC_P3_CNT1       5
`define PRC_P3_CMP        6
`define PRC_RAM_WORDS     128
`define PRC_RAM_AW        7
`endif

// file: design/prc_pkg.sv
// Types shared by the port, reset and clock block
package prc_pkg;
  typedef enum logic [1:0] {
    PRC_RUN   = 2'b00,
    PRC_IDLE  = 2'b01,
    PRC_PDOWN = 2'b10
  } prc_mode_t;

  typedef struct packed {
    logic       wr;
    logic       sel3;
    logic       rd_latch;
    logic [7:0] wdata;
  } prc_port_req_t;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } prc_ram_req_t;

  typedef struct packed {
    logic rxd;
    logic irq0;
    logic irq1;
    logic cnt0;
    logic cnt1;
  } prc_alt_in_t;
endpackage : prc_pkg

// file: design/prc_ram.sv
// On-chip data RAM, contents kept through reset
`timescale 1ns/1ps
`include "prc_consts.svh"
module prc_ram #(
  parameter int WORDS = `PRC_RAM_WORDS,
  parameter int AW    = `PRC_RAM_AW
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // Access
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata_r
);
  logic [7:0] mem [WORDS];

  always_ff @(posedge clk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else if (en) begin
      rdata_r <= mem[addr];
    end
  end
endmodule : prc_ram

// file: design/prc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module prc_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : prc_sync

// file: design/prc_top.sv
// Port, reset, clock and power-mode logic
// How it works
// - Port one: eight two-way pins, each output from latch or input.
// - Port one bits 2..7 have pull-ups; bits 0,1 only pull low.
// - Port one bits 0,1 feed comparator plus and minus inputs.
// - Port three: seven two-way pins with pull-ups, bits 0..5 and 7.
// - Port three bit 6 reads comparator output, no general-purpose use.
// - Port three alternates: serial rx/tx, irq zero/one, count zero/one.
// - Programming: port one carries code bytes, port three controls.
// - Reset pin high forces all pins to one with no clock.
// - Full reset only after reset pin high two machine cycles.
// - One machine cycle is twelve oscillator periods.
// - Oscillator input goes through a divide-by-two stage.
// - Idle stops CPU; RAM, timers, serial, interrupts keep running.
// - Power-down freezes oscillator, keeps RAM, until hardware reset.
// - Idle ends on any enabled interrupt or hardware reset.
// - Reset restores register defaults, RAM contents untouched.
`timescale 1ns/1ps
`include "prc_consts.svh"
module prc_top
  import prc_pkg::*;
#(
  parameter int MC_OSC  = `PRC_MC_OSC,
  parameter int RST_MC  = `PRC_RST_MC
) (
  // Clock and power-on reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // Board pins
  input  wire logic          reset_input_pin,
  input  wire logic [7:0]    p1_pin_i,
  output logic      [7:0]    p1_pin_o,
  output logic      [7:0]    p1_pin_oe_n,
  output logic      [7:0]    p1_pullup_en,
  input  wire logic [7:0]    p3_pin_i,
  output logic      [7:0]    p3_pin_o,
  output logic      [7:0]    p3_pin_oe_n,
  output logic      [7:0]    p3_pullup_en,
  output logic               osc_amp_output,
  // Comparator
  input  wire logic          cmp_out,
  output logic               comparator_plus_input,
  output logic               comparator_minus_input,
  // Core port access
  input  wire prc_port_req_t port_req,
  output logic      [7:0]    port_rdata,
  input  wire logic [7:0]    p3_alt_out,
  output prc_alt_in_t        alt_in,
  // Core RAM access
  input  wire prc_ram_req_t  ram_req,
  input  wire logic          ram_en,
  output logic      [7:0]    ram_rdata,
  // Power modes
  input  wire logic          idle_req,
  input  wire logic          pdown_req,
  input  wire logic          irq_pending,
  output prc_mode_t          mode,
  output logic               cpu_clk_en,
  output logic               periph_clk_en,
  output logic               mc_tick,
  output logic               sys_rst,
  // Flash programming
  input  wire logic          prog_mode,
  input  wire logic          prog_drive,
  input  wire logic [7:0]    prog_data_out,
  output logic      [7:0]    prog_data_in,
  output logic      [7:0]    prog_ctrl
);
  // ***************************************
  // Constants and local signals
  // ***************************************
  localparam int RST_CLKS = MC_OSC * RST_MC;
  localparam int PHASES   = MC_OSC / 2;
  localparam int CW       = $clog2(RST_CLKS + 1);
  localparam int PW       = $clog2(PHASES);

  logic [7:0]     p1_sync;
  logic [7:0]     p3_sync;
  logic           rstp_sync;
  logic           cmp_sync;
  logic [7:0]     p1_lat_r;
  logic [7:0]     p3_lat_r;
  logic [CW-1:0]  rst_cnt_r;
  logic           div2_r;
  logic [PW-1:0]  phase_r;
  prc_mode_t      mode_nxt;
  logic [7:0]     p1_oe_nxt;
  logic [7:0]     p3_oe_nxt;
  logic [7:0]     rd_nxt;

  // ***************************************
  // Input synchronisers
  // ***************************************
  prc_sync #(.W(8)) u_p1_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    (p1_pin_i),
    .q    (p1_sync)
  );

  prc_sync #(.W(8)) u_p3_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    (p3_pin_i),
    .q    (p3_sync)
  );

  prc_sync #(.W(2)) u_misc_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({reset_input_pin, cmp_out}),
    .q    ({rstp_sync, cmp_sync})
  );

  // ***************************************
  // Reset qualification
  // ***************************************
  wire osc_run   = (mode != PRC_PDOWN);
  wire rst_full  = (rst_cnt_r == CW'(RST_CLKS));
  wire pin_clr_n = nrst & ~reset_input_pin;
  wire cnt_inc   = rstp_sync && !rst_full;

  // Counts high samples; reset pin restarts a frozen oscillator
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_cnt_r <= '0;
    end else if (!rstp_sync) begin
      rst_cnt_r <= '0;
    end else if (cnt_inc) begin
      rst_cnt_r <= rst_cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sys_rst <= 1'b1;
    end else begin
      sys_rst <= rst_full;
    end
  end

  // ***************************************
  // Clock divider and machine cycle
  // ***************************************
  wire phase_en = osc_run && div2_r;
  wire phase_wr = (phase_r == PW'(PHASES - 1));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div2_r  <= 1'b0;
      phase_r <= '0;
      mc_tick <= 1'b0;
    end else begin
      if (osc_run || rstp_sync) begin
        div2_r <= ~div2_r;
      end
      if (phase_en) begin
        phase_r <= phase_wr ? '0 : phase_r + PW'(1);
      end
      mc_tick <= phase_en && phase_wr;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_amp_output <= 1'b1;
    end else if (osc_run) begin
      osc_amp_output <= ~div2_r;
    end
  end

  // ***************************************
  // Power modes
  // ***************************************
  always_comb begin
    mode_nxt = mode;
    unique case (mode)
      PRC_RUN: begin
        if (pdown_req) begin
          mode_nxt = PRC_PDOWN;
        end else if (idle_req) begin
          mode_nxt = PRC_IDLE;
        end
      end
      PRC_IDLE: begin
        if (irq_pending) begin
          mode_nxt = PRC_RUN;
        end
      end
      PRC_PDOWN: begin
        mode_nxt = PRC_PDOWN;
      end
      default: begin
        mode_nxt = PRC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode          <= PRC_RUN;
      cpu_clk_en    <= 1'b0;
      periph_clk_en <= 1'b0;
    end else begin
      mode          <= rst_full ? PRC_RUN : mode_nxt;
      // Next mode, so no CPU pulse leaks out on the edge that enters idle or power-down
      cpu_clk_en    <= phase_en && phase_wr && mode_nxt == PRC_RUN && !rst_full;
      periph_clk_en <= phase_en && phase_wr && !rst_full;
    end
  end

  // ***************************************
  // Port latches
  // ***************************************
  wire wr_p1 = port_req.wr && !port_req.sel3 && mode == PRC_RUN;
  wire wr_p3 = port_req.wr &&  port_req.sel3 && mode == PRC_RUN;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p1_lat_r <= `PRC_PORT_RST;
      p3_lat_r <= `PRC_PORT_RST;
    end else if (rst_full) begin
      p1_lat_r <= `PRC_PORT_RST;
      p3_lat_r <= `PRC_PORT_RST;
    end else begin
      if (wr_p1) begin
        p1_lat_r <= port_req.wdata;
      end
      if (wr_p3) begin
        p3_lat_r <= port_req.wdata | ~`PRC_P3_GPIO;
      end
    end
  end

  // ***************************************
  // Pin drive
  // ***************************************
  // Released when one; pulled high only where a pull-up exists
  assign p1_oe_nxt = (prog_mode && prog_drive) ? prog_data_out
                                               : p1_lat_r;
  assign p3_oe_nxt = (p3_lat_r & p3_alt_out) | ~`PRC_P3_GPIO;

  // Reset pin releases every pin at once, without a clock edge
  always_ff @(posedge clk or negedge pin_clr_n) begin
    if (!pin_clr_n) begin
      p1_pin_oe_n <= `PRC_PORT_RST;
      p3_pin_oe_n <= `PRC_PORT_RST;
    end else begin
      p1_pin_oe_n <= p1_oe_nxt;
      p3_pin_oe_n <= p3_oe_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p1_pin_o     <= 8'h00;
      p3_pin_o     <= 8'h00;
      p1_pullup_en <= `PRC_P1_PULLUP;
      p3_pullup_en <= `PRC_P3_PULLUP;
    end else begin
      p1_pin_o     <= 8'h00;
      p3_pin_o     <= 8'h00;
      p1_pullup_en <= `PRC_P1_PULLUP;
      p3_pullup_en <= `PRC_P3_PULLUP;
    end
  end

  // ***************************************
  // Pin and latch read
  // ***************************************
  wire [7:0] p3_rd_pin = {p3_sync[7], cmp_sync, p3_sync[5:0]};

  assign rd_nxt = port_req.sel3
                  ? (port_req.rd_latch ? p3_lat_r : p3_rd_pin)
                  : (port_req.rd_latch ? p1_lat_r : p1_sync);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_rdata             <= 8'h00;
      alt_in                 <= '1;
      comparator_plus_input  <= 1'b1;
      comparator_minus_input <= 1'b1;
      prog_data_in           <= 8'h00;
      prog_ctrl              <= 8'h00;
    end else begin
      port_rdata             <= rd_nxt;
      alt_in.rxd             <= p3_sync[`PRC_P3_RXD];
      alt_in.irq0            <= p3_sync[`PRC_P3_IRQ0];
      alt_in.irq1            <= p3_sync[`PRC_P3_IRQ1];
      alt_in.cnt0            <= p3_sync[`PRC_P3_CNT0];
      alt_in.cnt1            <= p3_sync[`PRC_P3_CNT1];
      comparator_plus_input  <= p1_sync[`PRC_P1_CMP_PLUS];
      comparator_minus_input <= p1_sync[`PRC_P1_CMP_MINUS];
      prog_data_in           <= prog_mode ? p1_sync : 8'h00;
      prog_ctrl              <= prog_mode ? p3_sync : 8'h00;
    end
  end

  // ***************************************
  // Data RAM
  // ***************************************
  // Blocked in power-down and while reset is held
  wire ram_ok = ram_en && mode != PRC_PDOWN && !rstp_sync;

  prc_ram u_ram (
    .clk     (clk),
    .nrst    (nrst),
    .en      (ram_ok),
    .we      (ram_req.we),
    .addr    (ram_req.addr),
    .wdata   (ram_req.wdata),
    .rdata_r (ram_rdata)
  );
endmodule : prc_top

// file: test/prc_board.sv
// Board model: pin resolution, pull-ups and comparator
`timescale 1ns/1ps
module prc_board (
  // Device side
  input  wire logic [7:0] p1_pin_oe_n,
  input  wire logic [7:0] p1_pullup_en,
  input  wire logic [7:0] p3_pin_oe_n,
  input  wire logic [7:0] p3_pullup_en,
  // Board drivers
  input  wire logic [7:0] p1_ext_en,
  input  wire logic [7:0] p1_ext_val,
  input  wire logic [7:0] p3_ext_en,
  input  wire logic [7:0] p3_ext_val,
  // Levels seen by the device
  output logic      [7:0] p1_pin_i,
  output logic      [7:0] p3_pin_i,
  output logic            cmp_out
);
  // Device sinks win; released lines follow a driver, else a pull-up; port one bits 0,1 read high undriven
  assign p1_pin_i = p1_pin_oe_n & ((p1_ext_en & p1_ext_val)
                    | (~p1_ext_en & (p1_pullup_en | 8'h03)));
  assign p3_pin_i = p3_pin_oe_n & ((p3_ext_en & p3_ext_val) | (~p3_ext_en & p3_pullup_en));
  assign cmp_out  = p1_pin_i[0] & ~p1_pin_i[1];
endmodule : prc_board

// file: test/prc_top_props.sv
// Checker of the port, reset and clock block ports
`timescale 1ns/1ps
module prc_top_props
  import prc_pkg::*;
#(
  parameter int MC_OSC = 12,
  parameter int RST_MC = 2
) (
  input wire logic          clk,
  input wire logic          nrst,
  input wire logic          reset_input_pin,
  input wire logic [7:0]    p1_pin_o,
  input wire logic [7:0]    p1_pin_oe_n,
  input wire logic [7:0]    p1_pullup_en,
  input wire logic [7:0]    p3_pin_o,
  input wire logic [7:0]    p3_pin_oe_n,
  input wire logic [7:0]    p3_pullup_en,
  input wire prc_port_req_t port_req,
  input wire logic          irq_pending,
  input wire logic          prog_mode,
  input wire prc_mode_t     mode,
  input wire logic          cpu_clk_en,
  input wire logic          periph_clk_en,
  input wire logic          mc_tick,
  input wire logic          sys_rst
);
  localparam int RST_CLKS = MC_OSC * RST_MC;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_pullup_map: assert property (p1_pullup_en == 8'hfc && p3_pullup_en == 8'hbf)
    else $error("pull-up map wrong");
  a_pins_low_only: assert property (p1_pin_o == 8'h00 && p3_pin_o == 8'h00)
    else $error("pin driven high");
  a_cmp_bit_free: assert property (p3_pin_oe_n[6])
    else $error("port three bit six driven");
  a_rst_pin_release: assert property (reset_input_pin
    |-> p1_pin_oe_n == 8'hff && p3_pin_oe_n == 8'hff)
    else $error("pins not released by reset pin");
  a_rst_after_count: assert property ($rose(sys_rst)
    |-> $past(reset_input_pin, RST_CLKS))
    else $error("internal reset too early");
  a_tick_spacing: assert property (mc_tick |=> (!mc_tick)[*8] ##1 (!mc_tick)[*3])
    else $error("machine cycle shorter than twelve clocks");
  a_cpu_en_run: assert property (cpu_clk_en |-> mc_tick && mode == PRC_RUN)
    else $error("cpu enable outside run tick");
  a_idle_irq_exit: assert property (mode == PRC_IDLE && irq_pending
    |-> ##[1:2] mode == PRC_RUN)
    else $error("idle not left on interrupt");
  a_pdown_quiet: assert property (mode == PRC_PDOWN && $past(mode) == PRC_PDOWN
    |-> !periph_clk_en && !cpu_clk_en)
    else $error("clock enable in power-down");
  a_pdown_exit_rst: assert property ($past(mode) == PRC_PDOWN && mode != PRC_PDOWN
    |-> sys_rst || $past(sys_rst))
    else $error("power-down left without reset");
  a_write_to_pin: assert property (port_req.wr && !port_req.sel3 && mode == PRC_RUN
    && !sys_rst && !reset_input_pin && !prog_mode |-> ##2 p1_pin_oe_n == $past(port_req.wdata, 2))
    else $error("port one write not on pins");

  c_idle_exit: cover property (mode == PRC_IDLE ##[1:2] mode == PRC_RUN);
  c_full_reset: cover property ($rose(sys_rst));
  c_p3_write: cover property (port_req.wr && port_req.sel3);
endmodule : prc_top_props

bind prc_top prc_top_props #(.MC_OSC(MC_OSC), .RST_MC(RST_MC)) u_props (.clk, .nrst,
  .reset_input_pin, .p1_pin_o, .p1_pin_oe_n, .p1_pullup_en, .p3_pin_o, .p3_pin_oe_n,
  .p3_pullup_en, .port_req, .irq_pending, .prog_mode, .mode, .cpu_clk_en, .periph_clk_en,
  .mc_tick, .sys_rst);

// file: test/test_port_reset_clock_logic.sv
// Self-checking bench for the port, reset and clock block
`timescale 1ns/1ps
module test_port_reset_clock_logic
  import prc_pkg::*;
;
  logic clk = 0, nrst = 0, reset_input_pin = 0, cmp_out, osc_amp_output;
  logic [7:0] p1_pin_i, p1_pin_o, p1_pin_oe_n, p1_pullup_en, p3_pin_i, p3_pin_o;
  logic [7:0] p3_pin_oe_n, p3_pullup_en, port_rdata, ram_rdata, prog_data_in, prog_ctrl;
  logic [7:0] p3_alt_out = 8'hff, p1_ext_en = 0, p1_ext_val = 0, p3_ext_en = 0, p3_ext_val = 0;
  logic comparator_plus_input, comparator_minus_input, cpu_clk_en, periph_clk_en;
  logic mc_tick, sys_rst, idle_req = 0, pdown_req = 0, irq_pending = 0, prog_mode = 0;
  logic ram_en = 0, o, prog_drive = 0;
  logic [7:0] prog_data_out = 0;
  logic [7:0] l1, l3, a3, v1, v3, d;
  prc_port_req_t port_req = '0;
  prc_ram_req_t ram_req = '0;
  prc_alt_in_t alt_in;
  prc_mode_t mode;
  int checks = 0, fail_count = 0, i, n, m;

  always #2.5 clk = ~clk;

  prc_top DUT (.clk, .nrst, .reset_input_pin, .p1_pin_i, .p1_pin_o, .p1_pin_oe_n, .p1_pullup_en,
    .p3_pin_i, .p3_pin_o, .p3_pin_oe_n, .p3_pullup_en, .osc_amp_output, .cmp_out,
    .comparator_plus_input, .comparator_minus_input, .port_req, .port_rdata, .p3_alt_out,
    .alt_in, .ram_req, .ram_en, .ram_rdata, .idle_req, .pdown_req, .irq_pending, .mode,
    .cpu_clk_en, .periph_clk_en, .mc_tick, .sys_rst, .prog_mode, .prog_drive,
    .prog_data_out, .prog_data_in, .prog_ctrl);
  prc_board u_board (.p1_pin_oe_n, .p1_pullup_en, .p3_pin_oe_n, .p3_pullup_en, .p1_ext_en,
    .p1_ext_val, .p3_ext_en, .p3_ext_val, .p1_pin_i, .p3_pin_i, .cmp_out);

  // ****************
  // Helpers
  // ****************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic wait_mode(input prc_mode_t m);
    for (int k = 0; k < 20 && mode !== m; k++) @(negedge clk);
    check(8'(mode), 8'(m));
    if (mode !== m) results();
  endtask : wait_mode
  // Leaves the strobe up so writes can run back to back
  task automatic wr_port(input logic s3, input logic [7:0] v);
    port_req = '{wr: 1'b1, sel3: s3, rd_latch: 1'b1, wdata: v};
    cyc(1);
  endtask : wr_port
  function automatic logic [7:0] exp_p3_oe(input logic [7:0] l, input logic [7:0] a);
    return (l & a) | 8'h40;
  endfunction : exp_p3_oe
  function automatic logic [7:0] exp_alt(input logic [7:0] p);
    return {3'h0, p[0], p[2], p[3], p[4], p[5]};
  endfunction : exp_alt

  // ****************
  // Sequence
  // ****************
  initial begin
    void'($urandom(89421));
    cyc(20);
    nrst = 1;
    cyc(2);
    check(p1_pullup_en, 8'hfc);
    check(p3_pullup_en, 8'hbf);
    for (i = 0; i < 16; i++) begin
      l1 = $urandom;
      l3 = $urandom;
      a3 = (i == 0) ? 8'hff : 8'($urandom);
      p3_alt_out = a3;
      wr_port(0, l1);
      wr_port(1, l3);
      port_req.wr = 0;
      cyc(2);
      check(p1_pin_oe_n, l1);
      check(p3_pin_oe_n, exp_p3_oe(l3, a3));
      port_req.sel3 = 0;
      cyc(1);
      check(port_rdata, l1);
      port_req.sel3 = 1;
      cyc(1);
      check(port_rdata, l3 | 8'h40);
    end
    p3_alt_out = 8'hff;
    wr_port(0, 8'hff);
    wr_port(1, 8'hff);
    port_req = '0;
    for (i = 0; i < 12; i++) begin
      p1_ext_en = $urandom;
      p1_ext_val = $urandom;
      p3_ext_en = 8'($urandom) & 8'hbf;
      p3_ext_val = $urandom;
      v1 = (p1_ext_en & p1_ext_val) | ~p1_ext_en;
      v3 = (p3_ext_en & p3_ext_val) | (~p3_ext_en & 8'hbf);
      port_req.sel3 = 0;
      prog_mode = (i > 9);
      cyc(4);
      check(port_rdata, v1);
      check({6'h0, comparator_minus_input, comparator_plus_input}, {6'h0, v1[1:0]});
      if (prog_mode) check(prog_data_in, v1);
      if (prog_mode) check(prog_ctrl & 8'hbf, v3);
      port_req.sel3 = 1;
      cyc(4);
      check(port_rdata, {v3[7], v1[0] & ~v1[1], v3[5:0]});
      check(8'(alt_in), exp_alt(v3));
    end
    // Programming drive puts code bytes on port one
    d = $urandom;
    prog_data_out = d;
    prog_drive = 1;
    cyc(2);
    check(p1_pin_oe_n, d);
    prog_drive = 0;
    prog_mode = 0;
    p1_ext_en = 0;
    n = 0;
    m = 0;
    for (i = 0; i < 120; i++) begin
      cyc(1);
      n += int'(mc_tick);
      m += int'(cpu_clk_en);
    end
    check(8'(n), 8'd10);
    check(8'(m), 8'd10);
    o = osc_amp_output;
    cyc(1);
    check({7'h0, osc_amp_output}, {7'h0, ~o});
    wr_port(0, 8'h00);
    port_req.wr = 0;
    idle_req = 1;
    cyc(1);
    idle_req = 0;
    wait_mode(PRC_IDLE);
    d = $urandom;
    ram_req = '{we: 1'b1, addr: 7'h7f, wdata: d};
    ram_en = 1;
    wr_port(0, 8'hff);
    port_req.wr = 0;
    ram_req.we = 0;
    cyc(3);
    check(p1_pin_oe_n, 8'h00);
    check(ram_rdata, d);
    // Peripherals keep their tick in idle, the CPU gets none
    n = 0;
    m = 0;
    for (i = 0; i < 24; i++) begin
      cyc(1);
      n += int'(periph_clk_en);
      m += int'(cpu_clk_en);
    end
    check(8'(n), 8'd2);
    check(8'(m), 8'd0);
    irq_pending = 1;
    cyc(1);
    irq_pending = 0;
    wait_mode(PRC_RUN);
    pdown_req = 1;
    cyc(1);
    pdown_req = 0;
    wait_mode(PRC_PDOWN);
    n = 0;
    o = osc_amp_output;
    for (i = 0; i < 30; i++) begin
      cyc(1);
      n += int'(mc_tick);
    end
    check(8'(n), 8'd0);
    check({7'h0, osc_amp_output}, {7'h0, o});
    reset_input_pin = 1;
    #1;
    check(p1_pin_oe_n & p3_pin_oe_n, 8'hff);
    cyc(10);
    reset_input_pin = 0;
    cyc(8);
    check({7'h0, sys_rst}, 8'h00);
    check(8'(mode), 8'(PRC_PDOWN));
    // Held beyond two machine cycles for a full reset
    reset_input_pin = 1;
    cyc(40);
    check({7'h0, sys_rst}, 8'h01);
    reset_input_pin = 0;
    cyc(8);
    check({7'h0, sys_rst}, 8'h00);
    wait_mode(PRC_RUN);
    check(p1_pin_oe_n, 8'hff);
    cyc(2);
    check(ram_rdata, d);
    results();
  end
endmodule : test_port_reset_clock_logic
